/* File: core/trig_map_consts.vh */
// Constants for the trigger output map block: offsets, fields, reset values.
// Assumes inclusion by bare name from core/ design files.
`ifndef TRIG_MAP_CONSTS_VH
`define TRIG_MAP_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_OUT6_EN      8'h00
`define OFS_OUT7_EN      8'h04
`define OFS_IN_STATE     8'h08
`define OFS_IRQ_STATUS   8'h0c
`define OFS_IRQ_MASK     8'h10
`define OFS_APP_CHAN     8'h14

// ****************************************************************
// Field widths and reset values
// ****************************************************************
`define CHAN_W           4
`define TRIG_W           8
`define MASK_RST         4'h0
`define APP_RST          4'h0
`define IRQ_W            2
`define IRQ_RST          2'h0
`define TRIG_RST         2'h0
`define DAT_RST          32'h00000000
`define ADDR_W           8

`endif

/* File: core/trig_out_map.v */
// Maps four event channels onto trigger outputs 6 and 7 and shows raw trigger inputs.
// Assumes a classic Wishbone master on clk_i; trigger inputs come from other clocks.
// Offsets and reset values come from the shared constants header.
// The input state view is raw and has no reset value.
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "trig_map_consts.vh"

module trig_out_map #(
  parameter CHAN_W = `CHAN_W,
  parameter TRIG_W = `TRIG_W
) (
  // Register bus
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output wire              wb_ack_o,
  // Trigger side
  input  wire [CHAN_W-1:0] chan_event_i,
  input  wire [TRIG_W-1:0] trig_in_i,
  output reg  [1:0]        trig_out_o,
  output wire              irq_o
);

  // ****************************************************************
  // Local constants
  // ****************************************************************
  localparam NUM_OUT = `IRQ_W;
  localparam WORD_W  = 32;
  localparam CPAD_W  = WORD_W - CHAN_W;
  localparam TPAD_W  = WORD_W - TRIG_W;
  localparam IPAD_W  = WORD_W - NUM_OUT;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Byte offsets, one per register
  localparam [`ADDR_W-1:0] ADR_OUT6  = `OFS_OUT6_EN;
  localparam [`ADDR_W-1:0] ADR_OUT7  = `OFS_OUT7_EN;
  localparam [`ADDR_W-1:0] ADR_INST  = `OFS_IN_STATE;
  localparam [`ADDR_W-1:0] ADR_ISTAT = `OFS_IRQ_STATUS;
  localparam [`ADDR_W-1:0] ADR_IMASK = `OFS_IRQ_MASK;
  localparam [`ADDR_W-1:0] ADR_APP   = `OFS_APP_CHAN;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // One address compare shared by every write strobe and the read path
  function adr_hit;
    input [`ADDR_W-1:0] adr;
    input [`ADDR_W-1:0] ofs;
    begin
      adr_hit = (adr == ofs);
    end
  endfunction

  // Widen a channel field to a bus word, reserved bits at zero
  function [WORD_W-1:0] chan_word;
    input [CHAN_W-1:0] val;
    begin
      chan_word = {{CPAD_W{1'b0}}, val};
    end
  endfunction

  // Widen the trigger input view to a bus word
  function [WORD_W-1:0] trig_word;
    input [TRIG_W-1:0] val;
    begin
      trig_word = {{TPAD_W{1'b0}}, val};
    end
  endfunction

  // Widen an interrupt field to a bus word
  function [WORD_W-1:0] irq_word;
    input [NUM_OUT-1:0] val;
    begin
      irq_word = {{IPAD_W{1'b0}}, val};
    end
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg  [CHAN_W-1:0] chan_meta_r;
  reg  [CHAN_W-1:0] chan_sync_r;
  reg  [TRIG_W-1:0] trig_meta_r;
  reg  [TRIG_W-1:0] trig_sync_r;

  // Two flops per input before any logic reads it
  // Left without reset: the input view carries no defined reset value
  always @(posedge clk_i) begin
    chan_meta_r <= chan_event_i;
  end

  always @(posedge clk_i) begin
    chan_sync_r <= chan_meta_r;
  end

  always @(posedge clk_i) begin
    trig_meta_r <= trig_in_i;
  end

  always @(posedge clk_i) begin
    trig_sync_r <= trig_meta_r;
  end

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  reg         ack_r;
  wire        bus_req;
  wire        wr_go;
  wire        rd_go;

  // The ack cycle blocks a second take of a strobe that is still held
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_r;
  // Writes need byte lane 0, where every field sits
  assign wr_go    = bus_req & wb_we_i & wb_sel_i[0];
  assign rd_go    = bus_req & ~wb_we_i;
  assign wb_ack_o = ack_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire        sel_out6;
  wire        sel_out7;
  wire        sel_in_state;
  wire        sel_irq_stat;
  wire        sel_irq_mask;
  wire        sel_app_chan;

  // One select per register offset
  assign sel_out6     = adr_hit(wb_adr_i, ADR_OUT6);
  assign sel_out7     = adr_hit(wb_adr_i, ADR_OUT7);
  assign sel_in_state = adr_hit(wb_adr_i, ADR_INST);
  assign sel_irq_stat = adr_hit(wb_adr_i, ADR_ISTAT);
  assign sel_irq_mask = adr_hit(wb_adr_i, ADR_IMASK);
  assign sel_app_chan = adr_hit(wb_adr_i, ADR_APP);

  // ****************************************************************
  // Write strobes and fields
  // ****************************************************************
  wire [CHAN_W-1:0]  wr_chan_fld;
  wire [NUM_OUT-1:0] wr_irq_fld;
  wire               wr_out6;
  wire               wr_out7;
  wire               wr_irq_stat;
  wire               wr_irq_mask;
  wire               wr_app_chan;

  assign wr_chan_fld = wb_dat_i[CHAN_W-1:0];
  assign wr_irq_fld  = wb_dat_i[NUM_OUT-1:0];
  // No strobe exists for the input state offset, so writes there are dropped
  assign wr_out6     = wr_go & sel_out6;
  assign wr_out7     = wr_go & sel_out7;
  assign wr_irq_stat = wr_go & sel_irq_stat;
  assign wr_irq_mask = wr_go & sel_irq_mask;
  assign wr_app_chan = wr_go & sel_app_chan;

  // ****************************************************************
  // Channel enable registers
  // ****************************************************************
  reg  [CHAN_W-1:0] out6_en_r;
  reg  [CHAN_W-1:0] out7_en_r;

  // Only the channel bits are stored; the reserved bits read back as zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      out6_en_r <= `MASK_RST;
    end else if (wr_out6) begin
      out6_en_r <= wr_chan_fld;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      out7_en_r <= `MASK_RST;
    end else if (wr_out7) begin
      out7_en_r <= wr_chan_fld;
    end
  end

  // ****************************************************************
  // Software channel drive
  // ****************************************************************
  reg  [CHAN_W-1:0] app_chan_r;

  // A level that is merged with the synchronised channel inputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      app_chan_r <= `APP_RST;
    end else if (wr_app_chan) begin
      app_chan_r <= wr_chan_fld;
    end
  end

  // ****************************************************************
  // Interrupt mask
  // ****************************************************************
  reg  [NUM_OUT-1:0] irq_mask_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= `IRQ_RST;
    end else if (wr_irq_mask) begin
      irq_mask_r <= wr_irq_fld;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg  [NUM_OUT-1:0] irq_stat_r;
  reg  [WORD_W-1:0]  rd_nxt;

  // Unmapped offsets read as zero
  always @* begin
    rd_nxt = 32'h00000000;
    if (sel_out6) begin
      rd_nxt = chan_word(out6_en_r);
    end
    if (sel_out7) begin
      rd_nxt = chan_word(out7_en_r);
    end
    if (sel_in_state) begin
      rd_nxt = trig_word(trig_sync_r);
    end
    if (sel_irq_stat) begin
      rd_nxt = irq_word(irq_stat_r);
    end
    if (sel_irq_mask) begin
      rd_nxt = irq_word(irq_mask_r);
    end
    if (sel_app_chan) begin
      rd_nxt = chan_word(app_chan_r);
    end
  end

  // Read data stands until the next read is taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `DAT_RST;
    end else if (rd_go) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ****************************************************************
  // Channel to trigger mapping
  // ****************************************************************
  wire [CHAN_W-1:0]         chan_act;
  wire [NUM_OUT*CHAN_W-1:0] mask_bus;
  wire [NUM_OUT-1:0]        trig_nxt;
  wire [NUM_OUT-1:0]        trig_rise;
  genvar                    k;

  // Software drive joins the channels ahead of the masks
  assign chan_act = chan_sync_r | app_chan_r;
  // Masks packed with the lower output first
  assign mask_bus = {out7_en_r, out6_en_r};

  // One slice per output: bit 0 is trigger output 6, bit 1 is output 7
  generate
    for (k = 0; k < NUM_OUT; k = k + 1) begin : g_out
      wire [CHAN_W-1:0] mask_k;
      wire [CHAN_W-1:0] hit_k;
      assign mask_k       = mask_bus[k*CHAN_W +: CHAN_W];
      assign hit_k        = chan_act & mask_k;
      assign trig_nxt[k]  = |hit_k;
      assign trig_rise[k] = trig_nxt[k] & ~trig_out_o[k];
    end
  endgenerate

  // ****************************************************************
  // Trigger outputs
  // ****************************************************************
  // Registered so decode glitches never reach the trigger lines
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_out_o <= `TRIG_RST;
    end else begin
      trig_out_o <= trig_nxt;
    end
  end

  // ****************************************************************
  // Interrupt status: rising trigger outputs, write one to clear
  // ****************************************************************
  reg  [NUM_OUT-1:0] irq_stat_nxt;
  wire [NUM_OUT-1:0] irq_clr;
  wire [NUM_OUT-1:0] irq_set;

  assign irq_clr = wr_irq_stat ? wr_irq_fld : {NUM_OUT{1'b0}};
  assign irq_set = trig_rise;

  // A rise in the same cycle as a clear wins, so no event is lost
  always @* begin
    irq_stat_nxt = irq_stat_r;
    irq_stat_nxt = irq_stat_nxt & ~irq_clr;
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= `IRQ_RST;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  // Level output: high while any unmasked status bit stands
  assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule // trig_out_map

/* File: testbench/trig_peer.sv */
// Trigger-side logic model: launches channel and input levels.
// Assumes the block's clock.
`timescale 1ns/10ps
module trig_peer (
  input  wire       clk_i,
  input  wire [3:0] ev_i,
  input  wire [7:0] tin_i,
  output reg  [3:0] chan_o = 4'h0,
  output reg  [7:0] trig_o = 8'h0
);
  always @(posedge clk_i) begin
    chan_o <= ev_i;
    trig_o <= tin_i;
  end
endmodule // trig_peer

/* File: testbench/trig_out_map_asserts.sv */
// Port checker for trig_out_map.
// Assumes it is bound to every instance.
`timescale 1ns/10ps
module tom_chk (
  input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i, chan_event_i,
  input wire [31:0] wb_dat_i, wb_dat_o,
  input wire [1:0] trig_out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [3:0] m6_r, m7_r, ap_r;
  // Shadow of masks and software drive, one cycle behind the block
  always @(posedge clk_i)
    if (rst_i) {m6_r, m7_r, ap_r} <= 12'h0;
    else if (wb_ack_o & wb_we_i & wb_sel_i[0])
      case (wb_adr_i)
        8'h00: m6_r <= wb_dat_i[3:0];
        8'h04: m7_r <= wb_dat_i[3:0];
        8'h14: ap_r <= wb_dat_i[3:0];
        default: ;
      endcase
  a_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_rsv_zero: assert property (wb_ack_o & !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("reserved bits set");
  a_dat_hold: assert property (!(wb_cyc_i & wb_stb_i & !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_out_quiet: assert property ((chan_event_i == 4'h0 && ap_r == 4'h0)[*4] |-> !trig_out_o)
    else $error("output without cause");
  a_out6_on: assert property ((((chan_event_i | ap_r) & m6_r) != 4'h0)[*4] |-> trig_out_o[0])
    else $error("output 6 missing");
  a_out7_on: assert property ((((chan_event_i | ap_r) & m7_r) != 4'h0)[*4] |-> trig_out_o[1])
    else $error("output 7 missing");
  a_reset_clear: assert property ($fell(rst_i) |-> !wb_ack_o && !trig_out_o && !irq_o)
    else $error("reset state wrong");
  c_out6: cover property (trig_out_o[0]);
  c_out7: cover property (trig_out_o[1]);
  c_irq: cover property (irq_o);
endmodule // tom_chk
bind trig_out_map tom_chk u_chk (.*);

/* File: testbench/tb_top.sv */
// Register-level bench for trig_out_map.
// Assumes trig_peer drives the trigger-side inputs.
`timescale 1ns/10ps
module tb_top;
  reg clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  reg [7:0] adr = 8'h0, tin = 8'h0;
  reg [31:0] dat = 32'h0, q;
  reg [3:0] ev = 4'h0;
  wire [31:0] rd;
  wire ack, irq;
  wire [1:0] tout;
  wire [3:0] chan;
  wire [7:0] trig;
  integer err_total = 0, num_checks = 0;
  always #2 clk_i = ~clk_i;
  trig_peer i_peer (.clk_i(clk_i), .ev_i(ev), .tin_i(tin), .chan_o(chan), .trig_o(trig));
  trig_out_map i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .chan_event_i(chan), .trig_in_i(trig), .trig_out_o(tout), .irq_o(irq));
  task complete_run;
    begin
      if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("BAD %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1; we <= w; adr <= a; dat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rd;
      cyc <= 1'b0;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  task to(input [1:0] e);
    begin
      repeat (6) @(posedge clk_i);
      chk({30'h0, tout}, {30'h0, e});
    end
  endtask
  initial begin
    #4000 err_total = err_total + 1;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h00, 32'hffffffff);
    rc(8'h00, 32'hf);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'h6);
    wb(1'b1, 8'h10, 32'h3);
    ev <= 4'h1;
    to(2'b01);
    ev <= 4'h4;
    to(2'b10);
    ev <= 4'h3;
    to(2'b11);
    ev <= 4'h6;
    to(2'b10);
    ev <= 4'h8;
    to(2'b00);
    rc(8'h0c, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h10, 32'h0);
    to(2'b00);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h10, 32'h3);
    wb(1'b1, 8'h0c, 32'h3);
    rc(8'h0c, 32'h0);
    wb(1'b1, 8'h14, 32'h1);
    to(2'b01);
    wb(1'b1, 8'h14, 32'h0);
    tin <= 8'ha5;
    to(2'b00);
    rc(8'h08, 32'ha5);
    wb(1'b1, 8'h08, 32'h0);
    rc(8'h08, 32'ha5);
    rc(8'h20, 32'h0);
    complete_run;
  end
endmodule // tb_top
